// ### logic/scbcs_top.sv
// Purpose: Clock configuration for one serial channel, Wishbone register port
// Assumes: Classic Wishbone slave on clk_i; link_clk_i is the peer's line clock
// Notes: Pin and foreign-clock levels are synchronised before use
//
// The Wishbone register port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`include "scbcs_params.svh"

// Overview of operation
// - Generator runs only while enable set
// - Timing select zero forces 16x on internal timing
// - Timing select one uses ratio fields on internal timing
// - External source forces 1x from pin
// - External transmit source blocks drive-out
// - Receive source: internal or pin A
// - Transmit source: internal or pin B
// - Receive clock drive-out on pin A
// - Transmit clock drive-out on pin B
// - Generator input: xtal, PLL, A, B
// - Transmit edge: falling, or rising inverted
// - Receive sample: rising, or falling inverted
// - Transmit ratio codes 1x/8x/16x/32x
// - Receive ratio codes same as transmit
module scbcs_top #(
  parameter int GEN_DIVISOR = `SCBCS_GEN_DIVISOR
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [`SCBCS_ADR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  input wire logic crystal_frequency_i,
  input wire logic pll_system_frequency_i,
  input wire logic aux_pin_a_i,
  output logic aux_pin_a_o,
  output logic aux_pin_a_oe_o,
  input wire logic aux_pin_b_i,
  output logic aux_pin_b_o,
  output logic aux_pin_b_oe_o,
  input wire logic link_clk_i,
  input wire logic rx_data_i,
  output logic [1:0] tx_mult_o,
  output logic [1:0] rx_mult_o,
  output logic tx_shift_o,
  output logic rx_sample_o,
  output logic rx_bit_o,
  output logic rx_valid_o
);

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  logic [31:0] cfg_q; // Configuration register
  logic ack_q; // Single-cycle acknowledge
  logic [31:0] rdat_q; // Registered read data
  logic [31:0] wmask; // Byte lanes merged with writable bits
  logic req; // New request this cycle
  logic [31:0] stat; // Status word

  assign req = wb_cyc_i && wb_stb_i && !ack_q;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}}
               & `SCBCS_CFG_WMASK;
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // Acknowledge one cycle after the request, dropped the next cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_q <= 1'b0;
    else
      ack_q <= req;
  end

  // Configuration write; only writable bits are stored
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cfg_q <= `SCBCS_CFG_RESET;
    else if (req && wb_we_i && wb_adr_i == `SCBCS_CFG_OFS)
      cfg_q <= (cfg_q & ~wmask) | (wb_dat_i & wmask);
  end

  // Read data; unmapped addresses read zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rdat_q <= 32'h0000_0000;
    else if (req && !wb_we_i)
    begin
      case (wb_adr_i)
        `SCBCS_CFG_OFS: rdat_q <= cfg_q & `SCBCS_CFG_WMASK;
        `SCBCS_STAT_OFS: rdat_q <= stat;
        default: rdat_q <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  logic gen_en; // Generator enable
  logic tsel; // Timing select
  logic rx_src; // Receive external timing
  logic tx_src; // Transmit external timing
  logic rx_drv; // Receive clock drive-out
  logic tx_drv; // Transmit clock drive-out
  logic [1:0] gsel; // Generator input select
  logic tx_inv; // Transmit edge invert
  logic rx_inv; // Receive edge invert
  logic [1:0] tx_osr; // Transmit ratio field
  logic [1:0] rx_osr; // Receive ratio field

  assign gen_en = cfg_q[`SCBCS_GEN_EN_BIT];
  assign tsel = cfg_q[`SCBCS_TSEL_BIT];
  assign rx_src = cfg_q[`SCBCS_RX_SRC_BIT];
  assign tx_src = cfg_q[`SCBCS_TX_SRC_BIT];
  assign rx_drv = cfg_q[`SCBCS_RX_DRV_BIT];
  assign tx_drv = cfg_q[`SCBCS_TX_DRV_BIT];
  assign gsel = cfg_q[`SCBCS_GSEL_HI:`SCBCS_GSEL_LO];
  assign tx_inv = cfg_q[`SCBCS_TX_INV_BIT];
  assign rx_inv = cfg_q[`SCBCS_RX_INV_BIT];
  assign tx_osr = cfg_q[`SCBCS_TX_OSR_HI:`SCBCS_TX_OSR_LO];
  assign rx_osr = cfg_q[`SCBCS_RX_OSR_HI:`SCBCS_RX_OSR_LO];

  // ----------------------------------------------------------------
  // Input synchronisers for foreign levels
  // ----------------------------------------------------------------
  logic [3:0] async_in; // xtal, pll, pin A, pin B
  logic [3:0] sync1_q; // First stage, read only by the second
  logic [3:0] sync2_q; // Usable levels

  assign async_in = {aux_pin_b_i, aux_pin_a_i, pll_system_frequency_i, crystal_frequency_i};

  // Two flip-flops per input
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_sync
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
        end
        else
        begin
          sync1_q[gi] <= async_in[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Bit-rate generator
  // ----------------------------------------------------------------
  logic src_lvl; // Selected generator input level
  logic src_prev_q; // Previous level for edge detect
  logic [15:0] gen_cnt_q; // Rising edges since last toggle
  logic gen_clk_q; // Internal bit-rate clock

  // Input source choice
  always_comb
  begin
    case (scbcs_pkg::scbcs_src_e'(gsel))
      scbcs_pkg::SCBCS_SRC_XTAL: src_lvl = sync2_q[0];
      scbcs_pkg::SCBCS_SRC_PLL: src_lvl = sync2_q[1];
      scbcs_pkg::SCBCS_SRC_AUXA: src_lvl = sync2_q[2];
      scbcs_pkg::SCBCS_SRC_AUXB: src_lvl = sync2_q[3];
      default: src_lvl = 1'b0;
    endcase
  end

  // Source edge history
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      src_prev_q <= 1'b0;
    else
      src_prev_q <= src_lvl;
  end

  // Divider, held cleared while disabled
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !gen_en)
    begin
      gen_cnt_q <= 16'h0000;
      gen_clk_q <= 1'b0;
    end
    else if (src_lvl && !src_prev_q)
    begin
      if (gen_cnt_q == 16'(GEN_DIVISOR - 1))
      begin
        gen_cnt_q <= 16'h0000;
        gen_clk_q <= !gen_clk_q;
      end
      else
        gen_cnt_q <= gen_cnt_q + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Direction clocks, multipliers and pin drive
  // ----------------------------------------------------------------
  logic rx_clk_q; // Selected receive clock
  logic tx_clk_q; // Selected transmit clock
  logic rx_prev_q; // Receive clock history
  logic tx_prev_q; // Transmit clock history
  logic [1:0] tx_mult_q; // Effective transmit multiplier
  logic [1:0] rx_mult_q; // Effective receive multiplier
  logic a_oe_q; // Pin A drive enable
  logic b_oe_q; // Pin B drive enable
  logic tx_shift_q; // Transmit data change pulse
  logic rx_sample_q; // Receive sample pulse

  // Source selection per direction
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rx_clk_q <= 1'b0;
      tx_clk_q <= 1'b0;
      rx_prev_q <= 1'b0;
      tx_prev_q <= 1'b0;
    end
    else
    begin
      rx_clk_q <= rx_src ? sync2_q[2] : gen_clk_q;
      tx_clk_q <= tx_src ? sync2_q[3] : gen_clk_q;
      rx_prev_q <= rx_clk_q;
      tx_prev_q <= tx_clk_q;
    end
  end

  // Effective multipliers: external 1x, else fixed 16x or fields
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tx_mult_q <= scbcs_pkg::SCBCS_OSR_16X;
      rx_mult_q <= scbcs_pkg::SCBCS_OSR_16X;
    end
    else
    begin
      if (tx_src)
        tx_mult_q <= scbcs_pkg::SCBCS_OSR_1X;
      else if (!tsel)
        tx_mult_q <= scbcs_pkg::SCBCS_OSR_16X;
      else
        tx_mult_q <= tx_osr;
      if (rx_src)
        rx_mult_q <= scbcs_pkg::SCBCS_OSR_1X;
      else if (!tsel)
        rx_mult_q <= scbcs_pkg::SCBCS_OSR_16X;
      else
        rx_mult_q <= rx_osr;
    end
  end

  // Pin drive enables; external transmit timing wins over drive-out
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      a_oe_q <= 1'b0;
      b_oe_q <= 1'b0;
    end
    else
    begin
      a_oe_q <= rx_drv;
      b_oe_q <= tx_drv && !tx_src;
    end
  end

  // Edge pulses in the requested polarity
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tx_shift_q <= 1'b0;
      rx_sample_q <= 1'b0;
    end
    else
    begin
      tx_shift_q <= (tx_clk_q != tx_prev_q) && (tx_clk_q == tx_inv);
      rx_sample_q <= (rx_clk_q != rx_prev_q) && (rx_clk_q != rx_inv);
    end
  end

  assign aux_pin_a_o = rx_clk_q;
  assign aux_pin_b_o = tx_clk_q;
  assign aux_pin_a_oe_o = a_oe_q;
  assign aux_pin_b_oe_o = b_oe_q;
  assign tx_mult_o = tx_mult_q;
  assign rx_mult_o = rx_mult_q;
  assign tx_shift_o = tx_shift_q;
  assign rx_sample_o = rx_sample_q;

  // ----------------------------------------------------------------
  // Link domain: line data capture on the peer's clock
  // ----------------------------------------------------------------
  logic lrst1_q; // Reset synchroniser, first stage
  logic lrst_q; // Reset in link domain
  logic linv1_q; // Invert synchroniser, first stage
  logic linv_q; // Receive invert in link domain
  logic cap_p_q; // Bit caught on rising edge
  logic tgl_p_q; // Rising capture event toggle
  logic cap_n_q; // Bit caught on falling edge
  logic tgl_n_q; // Falling capture event toggle

  // Control levels into the link domain
  always_ff @(posedge link_clk_i)
  begin
    lrst1_q <= rst_i;
    lrst_q <= lrst1_q;
    linv1_q <= rx_inv;
    linv_q <= linv1_q;
  end

  // Normal sampling on the rising edge
  always_ff @(posedge link_clk_i)
  begin
    if (lrst_q)
    begin
      cap_p_q <= 1'b0;
      tgl_p_q <= 1'b0;
    end
    else if (!linv_q)
    begin
      cap_p_q <= rx_data_i;
      tgl_p_q <= !tgl_p_q;
    end
  end

  // Inverted sampling on the falling edge
  always_ff @(negedge link_clk_i)
  begin
    if (lrst_q)
    begin
      cap_n_q <= 1'b0;
      tgl_n_q <= 1'b0;
    end
    else if (linv_q)
    begin
      cap_n_q <= rx_data_i;
      tgl_n_q <= !tgl_n_q;
    end
  end

  // ----------------------------------------------------------------
  // Capture events back into the register clock
  // ----------------------------------------------------------------
  logic [1:0] tg1_q; // First stage, read only by the second
  logic [1:0] tg2_q; // Synchronised toggles
  logic [1:0] tg3_q; // Toggle history for change detect
  logic rx_bit_q; // Last captured line bit
  logic rx_valid_q; // New bit pulse

  // Toggle synchronisers; the captured bit is stable while they settle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tg1_q <= 2'h0;
      tg2_q <= 2'h0;
      tg3_q <= 2'h0;
    end
    else
    begin
      tg1_q <= {tgl_n_q, tgl_p_q};
      tg2_q <= tg1_q;
      tg3_q <= tg2_q;
    end
  end

  // Take the bit whose toggle moved
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rx_bit_q <= 1'b0;
      rx_valid_q <= 1'b0;
    end
    else
    begin
      rx_valid_q <= |(tg2_q ^ tg3_q);
      if (tg2_q[0] ^ tg3_q[0])
        rx_bit_q <= cap_p_q;
      else if (tg2_q[1] ^ tg3_q[1])
        rx_bit_q <= cap_n_q;
    end
  end

  assign rx_bit_o = rx_bit_q;
  assign rx_valid_o = rx_valid_q;
  assign stat = {24'h000000, rx_bit_q, rx_mult_q, tx_mult_q, rx_clk_q, tx_clk_q, gen_clk_q};

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_gen_held_off: assert property (!gen_en |=> !gen_clk_q && gen_cnt_q == 16'h0000)
    else $error("generator ran while disabled");
  a_fixed_sixteen: assert property (!tsel && !tx_src |=> tx_mult_o == 2'h2)
    else $error("transmit not forced to 16x");
  a_tx_ratio_used: assert property (tsel && !tx_src |=> tx_mult_o == $past(tx_osr))
    else $error("transmit ratio field not applied");
  a_rx_ratio_used: assert property (tsel && !rx_src |=> rx_mult_o == $past(rx_osr))
    else $error("receive ratio field not applied");
  a_ext_one_x: assert property (rx_src |=> rx_mult_o == 2'h0)
    else $error("external receive not at 1x");
  a_rx_pin_clock: assert property (rx_src |=> aux_pin_a_o == $past(sync2_q[2]))
    else $error("receive clock not taken from pin A");
  a_tx_pin_clock: assert property (tx_src |=> aux_pin_b_o == $past(sync2_q[3]))
    else $error("transmit clock not taken from pin B");
  a_tx_drive_block: assert property (tx_src |=> !aux_pin_b_oe_o)
    else $error("pin B driven under external timing");
  a_rx_drive_out: assert property (##1 aux_pin_a_oe_o == $past(rx_drv))
    else $error("pin A drive does not follow its bit");
  a_tx_drive_out: assert property (tx_drv && !tx_src |=> aux_pin_b_oe_o)
    else $error("pin B not driven when asked");
  a_gen_source: assert property (GEN_DIVISOR > 1 && gen_en && gsel == 2'h2
    && sync2_q[2] && !src_prev_q && gen_cnt_q == 16'h0000 |=> gen_cnt_q == 16'h0001)
    else $error("generator input select wrong");
  a_tx_edge_pol: assert property (tx_shift_o |-> $past(tx_clk_q) == $past(tx_inv))
    else $error("transmit edge of wrong polarity");
  a_rx_edge_pol: assert property (rx_sample_o |-> $past(rx_clk_q) != $past(rx_inv))
    else $error("receive edge of wrong polarity");
  a_reset_clears: assert property (disable iff (1'b0) rst_i |=> cfg_q == 32'h0000_0000)
    else $error("configuration not cleared by reset");
  a_rsvd_zero: assert property (wb_ack_o |-> !wb_dat_o[21] && !cfg_q[21])
    else $error("reserved bit not zero");

  c_gen_toggle: cover property (gen_en ##1 $rose(gen_clk_q));
  c_tx_shift: cover property (tx_shift_o);
  c_rx_valid: cover property (rx_valid_o);
  c_pin_b_drive: cover property ($rose(aux_pin_b_oe_o));

endmodule

// ### inc/scbcs_params.svh
// Purpose: Offsets, field positions and reset values of the serial clock select block
// Assumes: Included by its bare name from the package and the design
// Notes: Definitions only
`ifndef SCBCS_PARAMS_SVH
`define SCBCS_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define SCBCS_ADR_W 8
`define SCBCS_CFG_OFS 8'h00
`define SCBCS_STAT_OFS 8'h04

// ----------------------------------------------------------------
// Configuration register fields
// ----------------------------------------------------------------
`define SCBCS_CFG_RESET 32'h0000_0000
`define SCBCS_CFG_WMASK 32'hffdb_0000
`define SCBCS_GEN_EN_BIT 31
`define SCBCS_TSEL_BIT 30
`define SCBCS_RX_SRC_BIT 29
`define SCBCS_TX_SRC_BIT 28
`define SCBCS_RX_DRV_BIT 27
`define SCBCS_TX_DRV_BIT 26
`define SCBCS_GSEL_HI 25
`define SCBCS_GSEL_LO 24
`define SCBCS_TX_INV_BIT 23
`define SCBCS_RX_INV_BIT 22
`define SCBCS_RSVD_BIT 21
`define SCBCS_TX_OSR_HI 20
`define SCBCS_TX_OSR_LO 19
`define SCBCS_RX_OSR_HI 17
`define SCBCS_RX_OSR_LO 16

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SCBCS_GEN_DIVISOR 8

`endif

// ### inc/scbcs_pkg.sv
// Purpose: Types of the serial clock select block
// Assumes: scbcs_params.svh on the include path
// Notes: Encodings used by the design; the bench uses literal values
`include "scbcs_params.svh"

package scbcs_pkg;

  // Oversampling multiplier codes
  typedef enum logic [1:0] {
    SCBCS_OSR_1X  = 2'h0,
    SCBCS_OSR_8X  = 2'h1,
    SCBCS_OSR_16X = 2'h2,
    SCBCS_OSR_32X = 2'h3
  } scbcs_osr_e;

  // Bit-rate generator input choices
  typedef enum logic [1:0] {
    SCBCS_SRC_XTAL = 2'h0,
    SCBCS_SRC_PLL  = 2'h1,
    SCBCS_SRC_AUXA = 2'h2,
    SCBCS_SRC_AUXB = 2'h3
  } scbcs_src_e;

endpackage

// ### verif/scbcs_peer.sv
// Purpose: Remote serial peer model driving the line clock and line data
// Assumes: Line clock period 48 ns, still between frames
// Notes: Data changes on the edge opposite the sampling edge
`timescale 1ns/1ns
module scbcs_peer (
  output logic link_clk_o,
  output logic rx_data_o
);
  // ----------------------------------------------------------------
  // Idle levels
  // ----------------------------------------------------------------
  initial
  begin
    link_clk_o = 1'b0;
    rx_data_o = 1'b0;
  end

  // Free edges so the link side leaves reset
  task automatic warm(input int n);
    #3;
    repeat (n)
    begin
      #24 link_clk_o = 1'b1;
      #24 link_clk_o = 1'b0;
    end
  endtask

  // One frame, most significant bit first; inv moves sampling to falling edge
  task automatic send(input logic [7:0] frame, input logic inv);
    int i;
    #3;
    for (i = 7; i >= 0; i--)
    begin
      if (!inv) rx_data_o = frame[i];
      #24 link_clk_o = 1'b1;
      if (inv) rx_data_o = frame[i];
      #24 link_clk_o = 1'b0;
    end
    // Released line shows the inverse of the last bit
    #24 rx_data_o = ~frame[0];
  endtask
endmodule

// ### verif/tb.sv
// Purpose: Self-checking bench of the serial clock select block
// Assumes: Classic Wishbone single cycles; peer model on the link
// Notes: Generator divisor shortened to 2
`timescale 1ns/1ns
module tb;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [3:0] wb_sel_i, src_run;
  logic xtal_q, pll_q, pin_a_drv, pin_b_drv, pin_a, pin_b;
  logic aux_pin_a_o, aux_pin_a_oe_o, aux_pin_b_o, aux_pin_b_oe_o;
  logic link_clk, rx_data, tx_shift_o, rx_sample_o, rx_bit_o, rx_valid_o;
  logic [1:0] tx_mult_o, rx_mult_o;
  logic [7:0] rx_got, fr;
  int mismatches, cmp_count, n_tx, n_rx, n_val, div, i, s, dt, dr, v0;
  localparam int GEN_DIV = 2; // Short generator divisor
  localparam logic [31:0] EN = 32'h8000_0000; // Generator enable
  localparam logic [31:0] TSEL = 32'h4000_0000; // Timing select
  localparam logic [31:0] RXS = 32'h2000_0000; // Receive external
  localparam logic [31:0] TXS = 32'h1000_0000; // Transmit external
  localparam logic [31:0] RXD = 32'h0800_0000; // Receive drive-out
  localparam logic [31:0] TXD = 32'h0400_0000; // Transmit drive-out
  localparam logic [31:0] INV = 32'h00c0_0000; // Both edge inverts

  // Pin wire levels from every driver
  assign pin_a = aux_pin_a_oe_o ? aux_pin_a_o : pin_a_drv;
  assign pin_b = aux_pin_b_oe_o ? aux_pin_b_o : pin_b_drv;

  scbcs_top #(.GEN_DIVISOR(GEN_DIV)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .crystal_frequency_i(xtal_q),
    .pll_system_frequency_i(pll_q), .aux_pin_a_i(pin_a), .aux_pin_a_o(aux_pin_a_o),
    .aux_pin_a_oe_o(aux_pin_a_oe_o), .aux_pin_b_i(pin_b), .aux_pin_b_o(aux_pin_b_o),
    .aux_pin_b_oe_o(aux_pin_b_oe_o), .link_clk_i(link_clk), .rx_data_i(rx_data),
    .tx_mult_o(tx_mult_o), .rx_mult_o(rx_mult_o), .tx_shift_o(tx_shift_o),
    .rx_sample_o(rx_sample_o), .rx_bit_o(rx_bit_o), .rx_valid_o(rx_valid_o));

  scbcs_peer u_peer (.link_clk_o(link_clk), .rx_data_o(rx_data));

  // ----------------------------------------------------------------
  // Clock, source clocks and pulse counters
  // ----------------------------------------------------------------
  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // Running sources toggle every fifth cycle; stopped crystal and PLL levels go low, stopped pin levels hold
  always @(posedge clk_i)
  begin
    div <= (div == 4) ? 0 : div + 1;
    if (div == 4)
    begin
      xtal_q <= src_run[0] ? ~xtal_q : 1'b0;
      pll_q <= src_run[1] ? ~pll_q : 1'b0;
      if (src_run[2]) pin_a_drv <= ~pin_a_drv;
      if (src_run[3]) pin_b_drv <= ~pin_b_drv;
    end
  end

  // Counts of edge pulses and received bits
  always @(posedge clk_i)
  begin
    n_tx <= n_tx + int'(tx_shift_o === 1'b1);
    n_rx <= n_rx + int'(rx_sample_o === 1'b1);
    if (rx_valid_o === 1'b1)
    begin
      n_val <= n_val + 1;
      rx_got <= {rx_got[6:0], rx_bit_o};
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Register value compare
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t: value %h, expected %h", $time, got, exp);
    end
  endtask

  // Event count compare against a range
  task automatic chk_rng(input int got, input int lo, input int hi);
    cmp_count++;
    if (got < lo || got > hi)
    begin
      mismatches++;
      $display("Error at %0t: count %0d, expected %0d..%0d", $time, got, lo, hi);
    end
  endtask

  // One classic single cycle; waits for ack under a bound
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                    output logic [31:0] rd);
    int t;
    t = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do
    begin
      @(posedge clk_i);
      t++;
    end
    while (wb_ack_o !== 1'b1 && t < 50);
    rd = wb_dat_o;
    if (t >= 50) chk(32'h0, 32'h1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  // Write, then let the change reach the outputs
  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    logic [31:0] d;
    wb(1'b1, adr, dat, d);
    repeat (3) @(posedge clk_i);
  endtask

  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] d;
    wb(1'b0, adr, 32'h0, d);
    chk(d, exp);
  endtask

  // Pulses seen over a window of n cycles
  task automatic win(input int n, output int t, output int q);
    int t0;
    int q0;
    t0 = n_tx;
    q0 = n_rx;
    repeat (n) @(posedge clk_i);
    t = n_tx - t0;
    q = n_rx - q0;
  endtask

  // ----------------------------------------------------------------
  // Watchdog and main sequence
  // ----------------------------------------------------------------
  initial
  begin
    #200000;
    mismatches++;
    print_verdict();
  end

  initial
  begin
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = {4'h8, 8'h00, 32'h0};
    {wb_sel_i, src_run, xtal_q, pll_q, pin_a_drv, pin_b_drv} = {4'hf, 4'h0, 4'h0};
    {mismatches, cmp_count, n_tx, n_rx, n_val, div} = {6{32'h0}};
    rx_got = 8'h00;
    fork
      u_peer.warm(3);
    join_none
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    // Reset state
    rd_chk(8'h00, 32'h0);
    chk({28'h0, tx_mult_o, rx_mult_o}, 32'ha);
    chk({28'h0, aux_pin_a_oe_o, aux_pin_b_oe_o, aux_pin_a_o, aux_pin_b_o}, 32'h0);
    // All ones: reserved places read zero, external sources force 1x
    wr(8'h00, 32'hffff_ffff);
    rd_chk(8'h00, 32'hffdb_0000);
    rd_chk(8'h10, 32'h0);
    chk({28'h0, tx_mult_o, rx_mult_o}, 32'h0);
    chk({30'h0, aux_pin_a_oe_o, aux_pin_b_oe_o}, 32'h2);
    // Timing select and ratio fields clear: fixed 16x
    wr(8'h00, 32'h0000_0000);
    chk({28'h0, tx_mult_o, rx_mult_o}, 32'ha);
    // Every ratio code with timing select
    for (i = 0; i < 4; i++)
    begin
      wr(8'h00, TSEL | (32'(i) << 19) | (32'(3 - i) << 16));
      chk({30'h0, tx_mult_o}, 32'(i));
      chk({30'h0, rx_mult_o}, 32'(3 - i));
    end
    // Drive-out enables with internal sources
    wr(8'h00, TXD);
    chk({30'h0, aux_pin_a_oe_o, aux_pin_b_oe_o}, 32'h1);
    wr(8'h00, RXD);
    chk({30'h0, aux_pin_a_oe_o, aux_pin_b_oe_o}, 32'h2);
    // Generator input select and enable, one source running at a time
    for (s = 0; s < 4; s++)
    begin
      src_run <= 4'(1 << s);
      wr(8'h00, EN | (32'(s) << 24));
      win(400, dt, dr);
      chk_rng(dr, 5, 20);
      wr(8'h00, EN | (32'((s + 1) % 4) << 24));
      win(30, dt, dr);
      win(400, dt, dr);
      chk_rng(dr, 0, 0);
      wr(8'h00, 32'(s) << 24);
      win(30, dt, dr);
      win(400, dt, dr);
      chk_rng(dr, 0, 0);
    end
    src_run <= 4'h0;
    // External pin clocks, both edge polarities; pins echo the chosen clocks
    for (i = 0; i < 2; i++)
    begin
      pin_a_drv <= 1'b0;
      pin_b_drv <= 1'b0;
      wr(8'h00, TXS | RXS | (i == 1 ? INV : 32'h0));
      win(30, dt, dr);
      pin_a_drv <= 1'b1;
      pin_b_drv <= 1'b1;
      win(30, dt, dr);
      chk_rng(dt, i, i);
      chk_rng(dr, 1 - i, 1 - i);
      chk({30'h0, aux_pin_a_o, aux_pin_b_o}, 32'h3);
      rd_chk(8'h04, 32'h6);
      pin_a_drv <= 1'b0;
      pin_b_drv <= 1'b0;
      win(30, dt, dr);
      chk_rng(dt, 1 - i, 1 - i);
      chk_rng(dr, i, i);
      chk({30'h0, aux_pin_a_o, aux_pin_b_o}, 32'h0);
    end
    // Link frames; a first frame carries the new polarity across
    for (i = 0; i < 2; i++)
    begin
      fr = (i == 1) ? 8'h4b : 8'hb4;
      wr(8'h00, (i == 1) ? INV : 32'h0);
      u_peer.send(8'h00, i[0]);
      repeat (12) @(posedge clk_i);
      v0 = n_val;
      u_peer.send(fr, i[0]);
      repeat (12) @(posedge clk_i);
      chk_rng(n_val - v0, 8, 8);
      chk({24'h0, rx_got}, {24'h0, fr});
      rd_chk(8'h04, {24'h0, fr[0], 7'h50});
    end
    print_verdict();
  end
endmodule
